//--- core/sbmi_core.sv
// ============================================================
// System bus master interface
// ============================================================
// Bus-side engine on the link clock, CPU request side and interrupt routing on clk.
// Assumes the pad ring resolves the enables into wire levels and slaves answer.
//
// Behaviour
// - Sixteen address lines carry the target location, top line most significant.
// - Eight two-way data lines carry read and write data, line seven most significant.
// - When sourcing the bus clock, produce 9.8304 MHz, 101.72 ns, 35-65 percent duty.
// - Provide a constant clock coincident with the bus clock, same period and duty.
// - Asserted priority-in means no higher master wants the bus; sample it synchronously.
// - Assert bus request synchronously while the bus is needed for transfers.
// - The holder drives busy; nobody takes the bus while busy is asserted.
// - Wanting the bus, drive priority-out to the inhibiting level.
// - Done with or not wanting the bus, drive priority-out to the enabling level.
// - Memory read: address valid, slave places the location's contents on data.
// - Memory write: address valid, slave stores the data lines' value.
// - I/O read: port address valid, port drives its output onto data.
// - I/O write: port address valid, port accepts the data lines' value.
// - System initialize resets everything; held at least 3000 ns after supplies settle. Here it only drops the link-side engine to idle and frees the bus.
// - Commands last at least 690 ns; same-type commands sit 475 ns apart.
// - Up to four of eight bus interrupt lines are inverted onto CPU inputs.
// - The port interrupt may drive one chosen bus interrupt line through an inverter.
`timescale 1ns/10ps
`default_nettype none
module sbmi_core
   import sbmi_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              link_clk,
   input  wire logic              req_valid,
   input  wire logic [1:0]        req_kind,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   req_busy,
   output logic                   req_done,
   output logic [DATA_W-1:0]      req_rdata,
   input  wire logic              init_n,
   input  wire logic              priority_in_n,
   output logic                   priority_out_n,
   output logic                   bus_request_n,
   input  wire logic              busy_in_n,
   output logic                   busy_out_n,
   output logic                   busy_oe,
   output logic                   bus_clock_n,
   output logic                   constant_clock_n,
   output logic [ADDR_W-1:0]      addr_lines_n,
   output logic                   addr_oe,
   input  wire logic [DATA_W-1:0] data_lines_n_in,
   output logic [DATA_W-1:0]      data_lines_n_out,
   output logic                   data_oe,
   output logic                   mem_read_cmd_n,
   output logic                   mem_write_cmd_n,
   output logic                   io_read_cmd_n,
   output logic                   io_write_cmd_n,
   output logic                   cmd_oe,
   input  wire logic              transfer_ack_n,
   input  wire logic [IRQ_N-1:0]  irq_lines_n_in,
   output logic [IRQ_N-1:0]       irq_lines_n_out,
   output logic [IRQ_N-1:0]       irq_lines_oe,
   input  wire logic [CPU_IRQS-1:0] route_en,
   input  wire logic [3*CPU_IRQS-1:0] route_sel,
   output logic [CPU_IRQS-1:0]    cpu_irq,
   input  wire logic              port_b_strobe_irq,
   input  wire logic              port_irq_en,
   input  wire logic [2:0]        port_irq_sel
);

   // ============================================================
   // CPU side: request capture and hand-off
   // ============================================================
   logic              req_tgl_q;
   logic [1:0]        kind_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [2:0]        dsync_q;
   logic              done_f_q;
   logic              done_seen_q;
   logic              done_tgl_q;
   logic [DATA_W-1:0] rdata_l_q;

   // Request words stay frozen while busy, so the link side may read them directly
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_tgl_q <= 1'b0;
         kind_q    <= 2'h0;
         addr_q    <= '0;
         wdata_q   <= '0;
      end else if (req_valid && !req_busy) begin
         req_tgl_q <= ~req_tgl_q;
         kind_q    <= req_kind;
         addr_q    <= req_addr;
         wdata_q   <= req_wdata;
      end
   end

   // Completion toggle crosses back; counted once the last two stages agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dsync_q  <= 3'h0;
         done_f_q <= 1'b0;
      end else begin
         dsync_q  <= {dsync_q[1:0], done_tgl_q};
         done_f_q <= (dsync_q[1] == dsync_q[2]) ? dsync_q[2] : done_f_q;
      end
   end

   // Done pulse, read data and busy flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_seen_q <= 1'b0;
         req_done    <= 1'b0;
         req_rdata   <= '0;
         req_busy    <= 1'b0;
      end else begin
         done_seen_q <= done_f_q;
         req_done    <= done_f_q != done_seen_q;
         if (done_f_q != done_seen_q) begin
            req_rdata <= rdata_l_q;  // Stable since its toggle was sent
         end
         if (done_f_q != done_seen_q) begin
            req_busy <= 1'b0;
         end else if (req_valid) begin
            req_busy <= 1'b1;
         end
      end
   end

   // ============================================================
   // Interrupt routing
   // ============================================================
   logic [IRQ_N-1:0] isync1_q;
   logic [IRQ_N-1:0] isync2_q;
   logic [IRQ_N-1:0] isync3_q;
   logic [IRQ_N-1:0] irq_f_q;

   // Bus interrupt lines are asynchronous pins: three stages and an agreement filter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         isync1_q <= '1;
         isync2_q <= '1;
         isync3_q <= '1;
         irq_f_q  <= '1;
      end else begin
         isync1_q <= irq_lines_n_in;
         isync2_q <= isync1_q;
         isync3_q <= isync2_q;
         irq_f_q  <= (~(isync2_q ^ isync3_q) & isync3_q) | ((isync2_q ^ isync3_q) & irq_f_q);
      end
   end

   // Each CPU input picks one line and inverts it to active high
   for (genvar gi = 0; gi < CPU_IRQS; gi++) begin : g_route
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            cpu_irq[gi] <= 1'b0;
         end else begin
            cpu_irq[gi] <= route_en[gi] & ~irq_f_q[route_sel[3*gi +: 3]];
         end
      end
   end

   // Port interrupt pulls one chosen open-drain line low
   for (genvar gj = 0; gj < IRQ_N; gj++) begin : g_port_irq
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            irq_lines_oe[gj]    <= 1'b0;
            irq_lines_n_out[gj] <= 1'b1;
         end else begin
            irq_lines_oe[gj]    <= port_irq_en && port_irq_sel == 3'(gj) && port_b_strobe_irq;
            irq_lines_n_out[gj] <= !(port_irq_en && port_irq_sel == 3'(gj) && port_b_strobe_irq);
         end
      end
   end

   // ============================================================
   // Link side: reset release and pin synchronisers
   // ============================================================
   logic [1:0]        lrst_q;
   logic              lrst_n;
   logic [SYNC_W-1:0] ps1_q;
   logic [SYNC_W-1:0] ps2_q;
   logic [SYNC_W-1:0] ps3_q;
   logic [SYNC_W-1:0] pf_q;
   logic [2:0]        rsync_q;
   logic              req_f_q;
   logic              req_seen_q;

   // Async assert, release aligned to the link clock
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign lrst_n = lrst_q[1];

   // Order: init, priority-in, busy, acknowledge, then data
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         ps1_q <= SYNC_RST;
         ps2_q <= SYNC_RST;
         ps3_q <= SYNC_RST;
         pf_q  <= SYNC_RST;
      end else begin
         ps1_q <= {init_n, priority_in_n, busy_in_n, transfer_ack_n, data_lines_n_in};
         ps2_q <= ps1_q;
         ps3_q <= ps2_q;
         pf_q  <= (~(ps2_q ^ ps3_q) & ps3_q) | ((ps2_q ^ ps3_q) & pf_q);
      end
   end

   // Request toggle from the CPU side
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         rsync_q <= 3'h0;
         req_f_q <= 1'b0;
      end else begin
         rsync_q <= {rsync_q[1:0], req_tgl_q};
         req_f_q <= (rsync_q[1] == rsync_q[2]) ? rsync_q[2] : req_f_q;
      end
   end

   logic init_act;
   logic prio_ok;
   logic bus_free;
   logic ack_act;
   logic pend;
   assign init_act = !pf_q[SYNC_W-1];
   assign prio_ok  = !pf_q[SYNC_W-2];
   assign bus_free = pf_q[SYNC_W-3];
   assign ack_act  = !pf_q[SYNC_W-4];
   assign pend     = req_f_q != req_seen_q;

   // ============================================================
   // Link side: bus clocks
   // ============================================================
   // Halving the link clock gives an even 50 percent duty, inside the allowed band
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         bus_clock_n      <= 1'b1;
         constant_clock_n <= 1'b1;
      end else begin
         bus_clock_n      <= ~bus_clock_n;
         constant_clock_n <= ~constant_clock_n;
      end
   end

   // ============================================================
   // Link side: ownership and command engine
   // ============================================================
   sbmi_state_e      state_q;
   sbmi_state_e      state_d;
   logic [CNT_W-1:0] st_cnt_q;
   logic [CNT_W-1:0] gap_q;
   logic [1:0]       last_kind_q;
   logic [1:0]       kind_l_q;
   logic             gap_ok;
   logic             own_d;

   assign gap_ok = gap_q >= CNT_W'((kind_l_q == last_kind_q) ? SEP_SAME_CYC : SEP_CROSS_CYC);
   assign own_d  = state_d == ST_SETUP || state_d == ST_CMD || state_d == ST_HOLD;

   // Next state; initialize drops everything back to idle
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:  if (pend) state_d = ST_REQ;
         ST_REQ:   if (prio_ok && bus_free) state_d = ST_SETUP;
         ST_SETUP: if (st_cnt_q >= CNT_W'(ADDR_SETUP_CYC - 1) && gap_ok) state_d = ST_CMD;
         ST_CMD:   if (st_cnt_q >= CNT_W'(CMD_WIDTH_CYC - 1) && ack_act) state_d = ST_HOLD;
         ST_HOLD:  if (st_cnt_q >= CNT_W'(ADDR_HOLD_CYC - 1)) state_d = pend ? ST_SETUP : ST_IDLE;
         default:  state_d = ST_IDLE;
      endcase
      if (init_act) begin
         state_d = ST_IDLE;
      end
   end

   // State and per-state cycle counter
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         state_q  <= ST_IDLE;
         st_cnt_q <= '0;
      end else begin
         state_q  <= state_d;
         st_cnt_q <= (state_d != state_q) ? '0 : st_cnt_q + CNT_W'(1);
      end
   end

   // Gap since the last command released, saturating
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         gap_q       <= GAP_RST;
         last_kind_q <= 2'h0;
      end else if (state_q == ST_CMD && state_d != ST_CMD) begin
         gap_q       <= CNT_W'(1);
         last_kind_q <= kind_l_q;
      end else if (gap_q != GAP_RST) begin
         gap_q <= gap_q + CNT_W'(1);
      end
   end

   // Transfer latch and completion hand-back
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         req_seen_q <= 1'b0;
         kind_l_q   <= 2'h0;
         done_tgl_q <= 1'b0;
         rdata_l_q  <= '0;
      end else begin
         if (state_d == ST_SETUP && state_q != ST_SETUP) begin
            req_seen_q <= req_f_q;
            kind_l_q   <= kind_q;
         end
         // An initialize that cuts a transfer still hands completion back, so the CPU side never stays busy
         if ((state_q == ST_CMD && state_d == ST_HOLD) ||
             (init_act && (state_q == ST_SETUP || state_q == ST_CMD))) begin
            done_tgl_q <= ~done_tgl_q;
         end
         if (state_q == ST_CMD && state_d == ST_HOLD) begin
            rdata_l_q  <= ~pf_q[DATA_W-1:0];
         end
      end
   end

   // Arbitration pins follow the next state so they line up with it
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         bus_request_n  <= 1'b1;
         priority_out_n <= 1'b0;
         busy_oe        <= 1'b0;
         busy_out_n     <= 1'b1;
      end else begin
         bus_request_n  <= state_d == ST_IDLE;
         priority_out_n <= state_d != ST_IDLE;
         busy_oe        <= own_d;
         busy_out_n     <= !own_d;
      end
   end

   // Address, data and command drivers, only while owning
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         addr_oe          <= 1'b0;
         addr_lines_n     <= '1;
         data_oe          <= 1'b0;
         data_lines_n_out <= '1;
         cmd_oe           <= 1'b0;
         {io_write_cmd_n, io_read_cmd_n, mem_write_cmd_n, mem_read_cmd_n} <= 4'hf;
      end else begin
         addr_oe          <= own_d;
         addr_lines_n     <= ~addr_q;
         data_oe          <= own_d && kind_q[0];
         data_lines_n_out <= ~wdata_q;
         cmd_oe           <= own_d;
         {io_write_cmd_n, io_read_cmd_n, mem_write_cmd_n, mem_read_cmd_n} <=
            ~((state_d == ST_CMD) ? (4'h1 << kind_l_q) : 4'h0);
      end
   end

   // ============================================================
   // Checks
   // ============================================================
   logic [3:0]       cmds;
   logic [CNT_W-1:0] low_q;
   assign cmds = ~{io_write_cmd_n, io_read_cmd_n, mem_write_cmd_n, mem_read_cmd_n};

   // Length of the current command pulse
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         low_q <= '0;
      end else begin
         low_q <= (cmds != 4'h0) ? low_q + CNT_W'(1) : '0;
      end
   end

   cmd_single_a: assert property (@(posedge link_clk) disable iff (!lrst_n) $onehot0(cmds))
      else $error("more than one command asserted");
   cmd_owned_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (cmds != 4'h0) |-> (busy_oe && !busy_out_n && cmd_oe && addr_oe))
      else $error("command without bus ownership");
   cmd_width_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      ($past(cmds) != 4'h0 && cmds == 4'h0 && !init_act && !$past(init_act)) |-> $past(low_q) >= CNT_W'(CMD_WIDTH_CYC - 1))
      else $error("command shorter than the least width");
   cmd_gap_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (state_q == ST_SETUP && state_d == ST_CMD) |-> gap_q >= CNT_W'(SEP_SAME_CYC))
      else $error("commands too close together");
   ack_wait_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (state_q == ST_CMD && state_d == ST_HOLD) |-> ack_act ##1 (cmds == 4'h0))
      else $error("command released without acknowledge");
   take_bus_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      $rose(busy_oe) |-> $past(prio_ok && bus_free))
      else $error("bus taken while busy or without priority");
   prio_out_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (state_q == ST_IDLE) |-> (!priority_out_n && bus_request_n))
      else $error("priority out wrong while idle");
   request_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (state_q == ST_REQ) |-> (!bus_request_n && priority_out_n && !busy_oe))
      else $error("bus request not asserted while waiting");
   bus_clock_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      $past(lrst_n) |-> (bus_clock_n == constant_clock_n) && (bus_clock_n != $past(bus_clock_n)))
      else $error("bus clocks not toggling together");
   init_drop_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
      init_act |=> (state_q == ST_IDLE) ##1 (!busy_oe && cmds == 4'h0))
      else $error("initialize did not release the bus");
   irq_route_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 cpu_irq[0] == $past(route_en[0] & ~irq_f_q[route_sel[2:0]]))
      else $error("interrupt routing mismatch");

endmodule
`default_nettype wire

//--- core/sbmi_pkg.sv
// ============================================================
// Shared constants for the system bus master interface
// ============================================================
// Holds widths, bus timing figures and the derived cycle counts.
// Assumes the link-side logic runs at twice the bus clock rate.
package sbmi_pkg;

   // ============================================================
   // Widths
   // ============================================================
   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 8;
   localparam int IRQ_N    = 8;
   localparam int CPU_IRQS = 4;
   localparam int CNT_W    = 8;
   localparam int SYNC_W   = 4 + DATA_W;

   // ============================================================
   // Bus timing, figures in their own units
   // ============================================================
   localparam longint LCLK_HZ        = 64'd19_660_800; // Twice the bus clock
   localparam longint NS_PER_S       = 64'd1_000_000_000;
   localparam int     BCLK_PERIOD_PS = 101720;
   localparam int     DUTY_MIN_PCT   = 35;
   localparam int     DUTY_MAX_PCT   = 65;
   localparam longint CMD_WIDTH_NS   = 64'd690;
   localparam longint SEP_SAME_NS    = 64'd475;
   localparam longint SEP_CROSS_NS   = 64'd980;
   localparam longint ADDR_SETUP_NS  = 64'd50;
   localparam longint ADDR_HOLD_NS   = 64'd50;
   localparam longint INIT_MIN_NS    = 64'd3000;

   // Least times round up, never below one cycle
   function automatic int sbmi_cyc(input longint ns);
      longint c;
      c = (ns * LCLK_HZ + NS_PER_S - 64'd1) / NS_PER_S;
      return (c < 64'd1) ? 1 : int'(c);
   endfunction

   localparam int CMD_WIDTH_CYC  = sbmi_cyc(CMD_WIDTH_NS);
   localparam int SEP_SAME_CYC   = sbmi_cyc(SEP_SAME_NS);
   localparam int SEP_CROSS_CYC  = sbmi_cyc(SEP_CROSS_NS);
   localparam int ADDR_SETUP_CYC = sbmi_cyc(ADDR_SETUP_NS);
   localparam int ADDR_HOLD_CYC  = sbmi_cyc(ADDR_HOLD_NS);

   // ============================================================
   // Reset values and encodings
   // ============================================================
   localparam logic [SYNC_W-1:0] SYNC_RST = '1;  // Inactive level of active-low pins
   localparam logic [CNT_W-1:0]  GAP_RST  = '1;  // No command yet, gap satisfied

   typedef enum logic [1:0] {
      CMD_MEM_RD = 2'h0,
      CMD_MEM_WR = 2'h1,
      CMD_IO_RD  = 2'h2,
      CMD_IO_WR  = 2'h3
   } sbmi_cmd_e;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_REQ   = 5'h02,
      ST_SETUP = 5'h04,
      ST_CMD   = 5'h08,
      ST_HOLD  = 5'h10
   } sbmi_state_e;

endpackage

//--- sim/sbmi_slave_model.sv
// Bus slave model: byte stores for memory and I/O that answer bus commands.
// Assumes resolved active-low bus wires and runs on the link clock.
`timescale 1ns/10ps
`default_nettype none
module sbmi_slave_model
   import sbmi_pkg::*;
(
   input  wire logic [3:0]        ack_dly,
   input  wire logic              link_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr_lines_n,
   input  wire logic [DATA_W-1:0] data_lines_n,
   input  wire logic [3:0]        cmd_n,
   output logic      [DATA_W-1:0] rd_data_n,
   output logic                   rd_oe,
   output logic                   transfer_ack_n
);
   logic [DATA_W-1:0] store_q [0:511];
   logic [3:0]        cnt_q;
   logic [8:0]        idx;
   // ============================================================
   // Slave behaviour
   // ============================================================
   // I/O ports live in the upper half of the store
   assign idx = {~(cmd_n[2] & cmd_n[3]), ~addr_lines_n[7:0]};
   // Read data is placed first, write data taken no later than acknowledge, so a slow slave is modelled too
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q          <= 4'h0;
         rd_oe          <= 1'b0;
         transfer_ack_n <= 1'b1;
      end else if (&cmd_n) begin
         cnt_q          <= 4'h0;
         rd_oe          <= 1'b0;
         transfer_ack_n <= 1'b1;
      end else begin
         if (!cmd_n[0] || !cmd_n[2]) begin
            rd_data_n <= ~store_q[idx];
            rd_oe     <= 1'b1;
         end
         if (cnt_q == 4'h1 && (!cmd_n[1] || !cmd_n[3])) store_q[idx] <= ~data_lines_n;
         if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
         transfer_ack_n <= !(cnt_q > ack_dly);
      end
   end
endmodule
`default_nettype wire

//--- sim/test_sbmi_core.sv
// Testbench: CPU transfers through the master to a slave model, arbitration, interrupts.
// Assumes the slave model and the package; pull-ups on busy and interrupt lines.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module test_sbmi_core
   import sbmi_pkg::*;
;
   logic clk, rst_n, link_clk, req_valid, req_busy, req_done, init_n, prio_n, prio_out_n, bus_request_n_n, oth_busy_n;
   logic busy_out_n, busy_oe, bclk_n, constant_clock_n_n, addr_oe, data_oe, cmd_oe, ack_n, rd_oe, strobe, pen;
   logic [1:0] kind;
   logic [ADDR_W-1:0] addr, addr_n;
   logic [DATA_W-1:0] wdata, rdata, dout_n, rd_n, r;
   logic [3:0] cmd_n, ack_dly, ren, cpu_irq;
   logic [11:0] rsel;
   logic [2:0] psel;
   logic [IRQ_N-1:0] ext_n, iout_n, ioe;
   int error_cnt = 0, comparisons = 0, cyc = 0, wid = 0, n;
   // ============================================================
   // Clocks, wires and watchers
   // ============================================================
   initial begin clk = 0; forever #50 clk = ~clk; end
   initial begin link_clk = 0; #7; forever #16 link_clk = ~link_clk; end
   wire busy_w = oth_busy_n & ~(busy_oe & ~busy_out_n);
   wire [IRQ_N-1:0] irq_w = ext_n & ~(ioe & ~iout_n);
   // Undriven data lines show a changing pattern so stale values cannot pass
   wire [DATA_W-1:0] data_w = data_oe ? dout_n : rd_oe ? rd_n : (8'h55 ^ {8{link_clk}});
   sbmi_core i_dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .req_valid(req_valid), .req_kind(kind),
      .req_addr(addr), .req_wdata(wdata), .req_busy(req_busy), .req_done(req_done), .req_rdata(rdata),
      .init_n(init_n), .priority_in_n(prio_n), .priority_out_n(prio_out_n), .bus_request_n(bus_request_n_n),
      .busy_in_n(busy_w), .busy_out_n(busy_out_n), .busy_oe(busy_oe), .bus_clock_n(bclk_n),
      .constant_clock_n(constant_clock_n_n), .addr_lines_n(addr_n), .addr_oe(addr_oe), .data_lines_n_in(data_w),
      .data_lines_n_out(dout_n), .data_oe(data_oe), .mem_read_cmd_n(cmd_n[0]), .mem_write_cmd_n(cmd_n[1]),
      .io_read_cmd_n(cmd_n[2]), .io_write_cmd_n(cmd_n[3]), .cmd_oe(cmd_oe), .transfer_ack_n(ack_n),
      .irq_lines_n_in(irq_w), .irq_lines_n_out(iout_n), .irq_lines_oe(ioe), .route_en(ren), .route_sel(rsel),
      .cpu_irq(cpu_irq), .port_b_strobe_irq(strobe), .port_irq_en(pen), .port_irq_sel(psel));
   sbmi_slave_model i_slave (.ack_dly(ack_dly), .link_clk(link_clk), .rst_n(rst_n), .addr_lines_n(addr_n),
      .data_lines_n(data_w), .cmd_n(cmd_n), .rd_data_n(rd_n), .rd_oe(rd_oe), .transfer_ack_n(ack_n));
   // Command width, ownership while commanding, clock coincidence
   always @(posedge link_clk) if (rst_n) begin
      `CHK(constant_clock_n_n, bclk_n)
      if (!(&cmd_n)) begin
         wid++;
         `CHK({busy_oe, cmd_oe, addr_oe, data_oe}, {3'h7, ~(cmd_n[1] & cmd_n[3])})
         `CHK(addr_n, ~addr)
      end
      else if (wid != 0) begin `CHK(wid >= CMD_WIDTH_CYC, 1'b1) wid = 0; end
   end
   // Hang guard: far beyond the longest expected run
   always @(posedge clk) begin cyc++; if (cyc == 60000) begin error_cnt++; complete_run(); end end
   task automatic complete_run();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Interrupt lines as the bus sees them, then routed and inverted
   function automatic logic [3:0] exp_irq();
      logic [IRQ_N-1:0] l;
      l = ext_n & ~({7'h0, pen & strobe} << psel);
      for (int i = 0; i < 4; i++) exp_irq[i] = ren[i] & ~l[rsel[3*i +: 3]];
   endfunction
   // ============================================================
   // Request tasks
   // ============================================================
   task automatic issue(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      req_valid = 1; kind = k; addr = a; wdata = d;
      @(negedge clk);
      req_valid = 0;
   endtask
   task automatic finish(output logic [7:0] q);
      for (n = 0; n < 3000 && req_done !== 1'b1; n++) @(negedge clk);
      `CHK({req_done, req_busy}, 2'h2)
      q = rdata;
      @(negedge clk);
   endtask
   // ============================================================
   // Scenarios
   // ============================================================
   initial begin
      rst_n = 0; req_valid = 0; kind = 0; addr = 0; wdata = 0; init_n = 1; prio_n = 0; oth_busy_n = 1;
      ack_dly = 0; ren = 0; rsel = 0; ext_n = '1; strobe = 0; pen = 0; psel = 0;
      repeat (20) @(posedge clk);
      @(negedge clk) rst_n = 1;
      void'($urandom(58342));
      `CHK({bus_request_n_n, prio_out_n, cmd_n}, 6'h2f)
      for (int i = 0; i < 12; i++) begin
         ack_dly = 4'($urandom % 10);
         addr = (i < 2) ? {16{i[0]}} : 16'($urandom);
         wdata = (i < 2) ? 8'h80 : 8'($urandom);
         issue({i[0], 1'b1}, addr, wdata);
         finish(r);
         issue({i[0], 1'b0}, addr, wdata);
         finish(r);
         `CHK(r, wdata)
      end
      for (int j = 0; j < 2; j++) begin
         prio_n = (j == 0); oth_busy_n = (j == 0); // Held off by a higher master, then by a second owner
         issue(2'h1, 16'h1234, 8'ha5);
         repeat (40) @(negedge clk);
         `CHK({bus_request_n_n, prio_out_n, cmd_oe, busy_oe, req_busy}, 5'h09)
         prio_n = 0; oth_busy_n = 1;
         finish(r);
      end
      for (int j = 0; j < 8; j++) begin
         ren = 4'($urandom); rsel = 12'($urandom); ext_n = 8'($urandom);
         pen = 1'($urandom); psel = 3'(j); strobe = 1'($urandom);
         repeat (8) @(negedge clk);
         `CHK(cpu_irq, exp_irq())
         `CHK(irq_w[psel], !(pen & strobe) & ext_n[psel])
      end
      prio_n = 1;
      issue(2'h0, 16'h0042, 8'h00);
      init_n = 0;
      repeat (31) @(negedge clk);
      `CHK({bus_request_n_n, prio_out_n, busy_oe}, 3'h4)
      complete_run();
   end
endmodule
`default_nettype wire
